// ==== bench/czg_host_model.sv ====
// Host processor model that writes and reads the trim bank
`timescale 1ns/1ps
`default_nettype none

module czg_host_model (
  input  wire logic                  clk,
  output logic                       wr_valid,
  output czg_pkg::czg_req_t          wr_req,
  output logic                       rd_valid,
  output czg_pkg::czg_req_t          rd_req,
  input  wire logic                  rd_ack,
  input  wire logic [15:0]           rd_data
);
  // Idle port, data lines never left looking like a request
  initial
  begin
    wr_valid = 1'b0;
    rd_valid = 1'b0;
    wr_req   = '0;
    rd_req   = '0;
  end

  // Trim code for an error given in steps: negated, twos complement
  function automatic logic [15:0] trim_code(input int err_steps);
    return 16'(-err_steps);
  endfunction : trim_code

  // One write pulse, driven between falling edges
  task automatic wr(input logic [1:0] ch, input czg_pkg::czg_kind_t k,
                    input logic [15:0] d);
    @(negedge clk);
    wr_req   = '{chan: ch, kind: k, data: d};
    wr_valid = 1'b1;
    @(negedge clk);
    wr_valid    = 1'b0;
    wr_req.data = ~d; // Stale data inverted, no free match
  endtask : wr

  // One read pulse; answer is taken one cycle after the request
  task automatic rd(input logic [1:0] ch, input czg_pkg::czg_kind_t k,
                    output logic [15:0] q, output logic ack);
    @(negedge clk);
    rd_req   = '{chan: ch, kind: k, data: 16'hffff};
    rd_valid = 1'b1;
    @(negedge clk);
    rd_valid = 1'b0;
    ack      = rd_ack;
    q        = rd_data;
  endtask : rd

  // Write, then read the same register at the very next edge
  task automatic wr_rd(input logic [1:0] ch, input czg_pkg::czg_kind_t k,
                       input logic [15:0] d, output logic [15:0] q,
                       output logic ack);
    @(negedge clk);
    wr_req   = '{chan: ch, kind: k, data: d};
    wr_valid = 1'b1;
    @(negedge clk);
    wr_valid    = 1'b0;
    wr_req.data = ~d; // Stale data inverted, no free match
    rd_req      = '{chan: ch, kind: k, data: 16'hffff};
    rd_valid    = 1'b1;
    @(negedge clk);
    rd_valid = 1'b0;
    ack      = rd_ack;
    q        = rd_data;
  endtask : wr_rd
endmodule : czg_host_model

`default_nettype wire

// ==== bench/tb_channel_zero_gain_calibration_regs.sv ====
// Self-checking bench for the channel zero and gain trim bank
`timescale 1ns/1ps
`default_nettype none

module tb_channel_zero_gain_calibration_regs;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   wr_valid, rd_valid, rd_ack;
  czg_pkg::czg_req_t      wr_req, rd_req;
  logic [15:0]            rd_data;
  logic [3:0]             upd = 4'h0;
  logic [3:0]             unipolar = 4'h0;
  logic [3:0][13:0]       code = '0;
  logic [3:0]             out_valid;
  logic [3:0][21:0]       out_code;
  logic [8:0]             zt [4];
  logic [7:0]             gt [4];
  int                     n_fail = 0;
  int                     compares = 0;

  always #5 clk = ~clk;

  czg_trim_regs dut_u (.clk(clk), .rst_n(rst_n), .wr_valid(wr_valid),
    .wr_req(wr_req), .rd_valid(rd_valid), .rd_req(rd_req), .rd_ack(rd_ack),
    .rd_data(rd_data), .upd(upd), .unipolar(unipolar), .code(code),
    .out_valid(out_valid), .out_code(out_code));
  czg_host_model host_u (.clk(clk), .wr_valid(wr_valid), .wr_req(wr_req),
    .rd_valid(rd_valid), .rd_req(rd_req), .rd_ack(rd_ack),
    .rd_data(rd_data));

  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Trimmed code in 1/32 LSB; gain scaled by fraction of span
  function automatic logic [21:0] model(input bit u, input logic [13:0] c,
                                        input logic [8:0] z,
                                        input logic [7:0] g);
    int x;
    int p;
    x = u ? int'(c) : int'($signed(c));
    p = int'($signed(g)) * x;
    return 22'(x * 32 + int'($signed(z)) + (u ? p >>> 11 : p >>> 10));
  endfunction : model

  task automatic rd_chk(input int ch, input bit k, input logic [15:0] exp);
    logic [15:0] q;
    logic        a;
    host_u.rd(2'(ch), czg_pkg::czg_kind_t'(k), q, a);
    chk({21'h0, a}, 22'h1);
    chk({6'h0, q}, {6'h0, exp});
  endtask : rd_chk

  // Back-to-back write and read of one register
  task automatic wr_rd_chk(input int ch, input bit k, input logic [15:0] d,
                           input logic [15:0] exp);
    logic [15:0] q;
    logic        a;
    host_u.wr_rd(2'(ch), czg_pkg::czg_kind_t'(k), d, q, a);
    chk({21'h0, a}, 22'h1);
    chk({6'h0, q}, {6'h0, exp});
  endtask : wr_rd_chk

  task automatic upd_ch(input int c, input bit u, input logic [13:0] cd);
    @(negedge clk);
    upd[c]      = 1'b1;
    unipolar[c] = u;
    code[c]     = cd;
    @(negedge clk);
    upd[c] = 1'b0;
    chk({21'h0, out_valid[c]}, 22'h1);
    chk(out_code[c], model(u, cd, zt[c], gt[c]));
  endtask : upd_ch

  // Every trim register reads zero after reset
  task automatic t_reset;
    for (int c = 0; c < 4; c++)
    begin
      rd_chk(c, 0, 16'h0000);
      rd_chk(c, 1, 16'h0000);
    end
    $display("test reset done");
  endtask : t_reset

  // Field widths, dropped upper bits and host step codes
  task automatic t_fields;
    wr_rd_chk(1, 0, 16'hffff, 16'h01ff);
    wr_rd_chk(2, 1, 16'hffff, 16'h00ff);
    host_u.wr(2'd3, czg_pkg::CZG_ZERO, host_u.trim_code(26));
    rd_chk(3, 0, 16'h01e6);
    host_u.wr(2'd0, czg_pkg::CZG_GAIN, host_u.trim_code(33));
    rd_chk(0, 1, 16'h00df);
    $display("test fields done");
  endtask : t_fields

  // Trim extremes on channels 0 and 1, one-step trims on 2 and 3, in both modes
  task automatic t_path;
    logic [8:0]  zv [4] = '{9'h0ff, 9'h100, 9'h001, 9'h1ff};
    logic [7:0]  gv [4] = '{8'h7f, 8'h80, 8'h01, 8'hff};
    logic [13:0] cv [4] = '{14'h1fff, 14'h2000, 14'h3fff, 14'h0001};
    for (int c = 0; c < 4; c++)
    begin
      zt[c] = zv[c];
      gt[c] = gv[c];
      host_u.wr(2'(c), czg_pkg::CZG_ZERO, {7'h7f, zv[c]});
      host_u.wr(2'(c), czg_pkg::CZG_GAIN, {8'ha5, gv[c]});
      upd_ch(c, 1'b0, cv[c]);
      upd_ch(c, 1'b1, cv[3 - c]);
    end
    $display("test path done");
  endtask : t_path

  // A trim write touches only its channel, and only at its next update
  task automatic t_iso;
    logic [21:0] held;
    held  = out_code[0];
    zt[0] = 9'h001;
    gt[0] = 8'h00;
    host_u.wr(2'd0, czg_pkg::CZG_ZERO, 16'h0001);
    // Gain of zero leaves the zero shift alone; upper bits are ignored
    host_u.wr(2'd0, czg_pkg::CZG_GAIN, 16'hff00);
    chk(out_code[0], held);
    upd_ch(1, 1'b0, 14'h0100);
    upd_ch(0, 1'b0, 14'h0001);
    $display("test isolation done");
  endtask : t_iso

  // Negative full scale with one negative gain step and no zero trim
  task automatic t_corner;
    zt[3] = 9'h000;
    gt[3] = 8'hff;
    host_u.wr(2'd3, czg_pkg::CZG_ZERO, 16'h0000);
    host_u.wr(2'd3, czg_pkg::CZG_GAIN, 16'h00ff);
    upd_ch(3, 1'b0, 14'h2000);
    chk(out_code[3], 22'h3c0008);
    $display("test corner done");
  endtask : t_corner

  // A reset in mid-run clears written trims and outputs again
  task automatic t_rerst;
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk(out_code[3], 22'h000000);
    t_reset();
    $display("test mid-run reset done");
  endtask : t_rerst

  task automatic wrap_up;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_fields();
    t_path();
    t_iso();
    t_corner();
    t_rerst();
    wrap_up();
  end

  // Tests need about a hundred cycles; far longer means a hang
  initial
  begin
    #50000;
    n_fail++;
    wrap_up();
  end
endmodule : tb_channel_zero_gain_calibration_regs

`default_nettype wire

// ==== rtl/czg_pkg.sv ====
// Shared constants and types for the channel zero and gain trim bank
package czg_pkg;
  localparam int NUM_CH          = 4;   // Converter channels
  localparam int CH_W            = 2;   // Channel index width
  localparam int WORD_W          = 16;  // Register word width
  localparam int ZERO_W          = 9;   // Zero trim field width
  localparam int ZERO_LSB        = 0;   // Zero trim field position
  localparam int GAIN_W          = 8;   // Gain trim field width
  localparam int GAIN_LSB        = 0;   // Gain trim field position
  localparam int DATA_W          = 14;  // Channel data code width
  localparam int FRAC_W          = 5;   // 1/32 LSB fraction: zero step
  localparam int GAIN_STEP_SHIFT = 3;   // Gain step 0.25 LSB = 8/32 LSB
  localparam int FS_SHIFT_BIP    = 13;  // Half span of a bipolar code
  localparam int FS_SHIFT_UNI    = 14;  // Span of a unipolar code
  localparam int BIP_SHIFT       = FS_SHIFT_BIP - GAIN_STEP_SHIFT;
  localparam int UNI_SHIFT       = FS_SHIFT_UNI - GAIN_STEP_SHIFT;
  localparam int OUT_W           = 22;  // Corrected code, 1/32 LSB units
  localparam logic [ZERO_W-1:0] ZERO_RST = 9'h000;
  localparam logic [GAIN_W-1:0] GAIN_RST = 8'h00;

  // Which trim register of a channel an access names
  typedef enum logic {
    CZG_ZERO,
    CZG_GAIN
  } czg_kind_t;

  // One register access from the serial front end
  typedef struct packed {
    logic [CH_W-1:0]   chan;
    czg_kind_t         kind;
    logic [WORD_W-1:0] data;
  } czg_req_t;
endpackage : czg_pkg

// ==== rtl/czg_trim_regs.sv ====
// Per-channel zero and gain trim registers and the trimmed data path
`timescale 1ns/1ps
`default_nettype none

module czg_trim_regs #(
  parameter int NUM_CH = czg_pkg::NUM_CH
) (
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  input  wire logic                                   wr_valid,
  input  wire czg_pkg::czg_req_t                      wr_req,
  input  wire logic                                   rd_valid,
  input  wire czg_pkg::czg_req_t                      rd_req,
  output logic                                        rd_ack,
  output logic [czg_pkg::WORD_W-1:0]                  rd_data,
  input  wire logic [NUM_CH-1:0]                      upd,
  input  wire logic [NUM_CH-1:0]                      unipolar,
  input  wire logic [NUM_CH-1:0][czg_pkg::DATA_W-1:0] code,
  output logic [NUM_CH-1:0]                           out_valid,
  output logic [NUM_CH-1:0][czg_pkg::OUT_W-1:0]       out_code
);

  // The channel index field cannot name more channels than this
  if (NUM_CH < 1 || NUM_CH > (1 << czg_pkg::CH_W))
  begin : g_bad_num_ch
    $error("NUM_CH out of range for the channel index field");
  end

  logic [czg_pkg::ZERO_W-1:0] zero_trim      [NUM_CH];
  logic [czg_pkg::GAIN_W-1:0] gain_trim      [NUM_CH];
  logic [czg_pkg::ZERO_W-1:0] next_zero_trim [NUM_CH];
  logic [czg_pkg::GAIN_W-1:0] next_gain_trim [NUM_CH];
  logic                       next_rd_ack;
  logic [czg_pkg::WORD_W-1:0] next_rd_data;

  // Register writes: only the trim field is kept, upper bits dropped
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      next_zero_trim[i] = zero_trim[i];
      next_gain_trim[i] = gain_trim[i];
      if (wr_valid && int'(wr_req.chan) == i)
      begin
        if (wr_req.kind == czg_pkg::CZG_ZERO)
          next_zero_trim[i] = wr_req.data[czg_pkg::ZERO_LSB +:
                                          czg_pkg::ZERO_W];
        else
          next_gain_trim[i] = wr_req.data[czg_pkg::GAIN_LSB +:
                                          czg_pkg::GAIN_W];
      end
    end
  end

  // Reset clears every trim to zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        zero_trim[i] <= czg_pkg::ZERO_RST;
        gain_trim[i] <= czg_pkg::GAIN_RST;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        zero_trim[i] <= next_zero_trim[i];
        gain_trim[i] <= next_gain_trim[i];
      end
    end
  end

  // Readback shows the stored value before a same-cycle write lands
  always_comb
  begin
    next_rd_ack  = rd_valid;
    next_rd_data = rd_data;
    if (rd_valid)
    begin
      next_rd_data = '0; // Absent channel reads as zero
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (int'(rd_req.chan) == i)
        begin
          if (rd_req.kind == czg_pkg::CZG_ZERO)
            next_rd_data = {{(czg_pkg::WORD_W-czg_pkg::ZERO_W){1'b0}},
                            zero_trim[i]};
          else
            next_rd_data = {{(czg_pkg::WORD_W-czg_pkg::GAIN_W){1'b0}},
                            gain_trim[i]};
        end
      end
    end
  end

  // Read answer registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_ack  <= 1'b0;
      rd_data <= '0;
    end
    else
    begin
      rd_ack  <= next_rd_ack;
      rd_data <= next_rd_data;
    end
  end

  // Per-channel correction, held until that channel's own update strobe
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    localparam int PROD_W = czg_pkg::WORD_W + czg_pkg::GAIN_W;
    logic signed [czg_pkg::WORD_W-1:0] ext;
    logic signed [PROD_W-1:0]          prod;
    logic signed [czg_pkg::OUT_W-1:0]  gterm;
    logic signed [czg_pkg::OUT_W-1:0]  sum;
    logic [czg_pkg::OUT_W-1:0]         next_out;
    logic                              next_valid;

    // Gain scales with the code's fraction of span; zero simply adds
    always_comb
    begin
      if (unipolar[c])
        ext = $signed({2'b00, code[c]});
      else
        ext = $signed({{2{code[c][czg_pkg::DATA_W-1]}}, code[c]});
      prod = $signed(gain_trim[c]) * ext;
      if (unipolar[c])
        gterm = czg_pkg::OUT_W'(prod >>> czg_pkg::UNI_SHIFT);
      else
        gterm = czg_pkg::OUT_W'(prod >>> czg_pkg::BIP_SHIFT);
      sum = (czg_pkg::OUT_W'(ext) <<< czg_pkg::FRAC_W)
          + czg_pkg::OUT_W'($signed(zero_trim[c]))
          + gterm;
      next_out   = upd[c] ? sum : out_code[c];
      next_valid = upd[c];
    end

    // Output latch of the channel
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        out_code[c]  <= '0;
        out_valid[c] <= 1'b0;
      end
      else
      begin
        out_code[c]  <= next_out;
        out_valid[c] <= next_valid;
      end
    end

    // Updated output carries the data shifted by the zero trim alone
    // when gain trim is zero
    property p_zero_shift;
      @(posedge clk) disable iff (!rst_n)
      (upd[c] && gain_trim[c] == '0) |=>
        $signed(out_code[c]) == ($signed(czg_pkg::OUT_W'($past(ext)))
          <<< czg_pkg::FRAC_W) + $signed($past(zero_trim[c]));
    endproperty
    a_zero_shift: assert property (p_zero_shift)
      else $error("Zero trim not applied as signed 1/32 LSB steps");

    // Without an update the channel output holds through any trim write
    sequence s_idle2;
      !upd[c] [*2];
    endsequence
    property p_hold;
      @(posedge clk) disable iff (!rst_n)
      s_idle2 |-> $stable(out_code[c]) && !out_valid[c];
    endproperty
    a_hold: assert property (p_hold)
      else $error("Channel output moved without its update");

    // Negative full-scale bipolar code with one negative gain step adds exactly 8/32 LSB
    property p_gain_step;
      @(posedge clk) disable iff (!rst_n)
      (upd[c] && !unipolar[c] && zero_trim[c] == '0 &&
       code[c] == 14'h2000 && gain_trim[c] == 8'hff) |=>
        $signed(out_code[c]) == -(22'sh040000) + 22'sh000008;
    endproperty
    a_gain_step: assert property (p_gain_step)
      else $error("Negative gain step at negative full scale wrong");

    // Unipolar code is straight binary: top code stays positive
    property p_unipolar;
      @(posedge clk) disable iff (!rst_n)
      (upd[c] && unipolar[c] && code[c] == 14'h3fff) |=>
        !out_code[c][czg_pkg::OUT_W-1];
    endproperty
    a_unipolar: assert property (p_unipolar)
      else $error("Unipolar code treated as signed");
  end

  // After reset the zero and gain trims of channel 0 are zero
  property p_reset_clear;
    @(posedge clk)
    !rst_n |=> (zero_trim[0] == '0 && gain_trim[0] == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("Trim not cleared by reset");

  // A zero trim write reads back masked to its field two cycles on
  sequence s_zero_wr_rd;
    wr_valid && wr_req.kind == czg_pkg::CZG_ZERO ##1
    rd_valid && rd_req.kind == czg_pkg::CZG_ZERO &&
    rd_req.chan == $past(wr_req.chan) && !wr_valid;
  endsequence
  property p_zero_rdback;
    @(posedge clk) disable iff (!rst_n)
    s_zero_wr_rd |=> rd_ack &&
      rd_data == {7'h00, $past(wr_req.data[8:0], 2)};
  endproperty
  a_zero_rdback: assert property (p_zero_rdback)
    else $error("Zero trim readback differs from masked write");

  // A gain trim write reads back masked to its field two cycles on
  sequence s_gain_wr_rd;
    wr_valid && wr_req.kind == czg_pkg::CZG_GAIN ##1
    rd_valid && rd_req.kind == czg_pkg::CZG_GAIN &&
    rd_req.chan == $past(wr_req.chan) && !wr_valid;
  endsequence
  property p_gain_rdback;
    @(posedge clk) disable iff (!rst_n)
    s_gain_wr_rd |=> rd_ack &&
      rd_data == {8'h00, $past(wr_req.data[7:0], 2)};
  endproperty
  a_gain_rdback: assert property (p_gain_rdback)
    else $error("Gain trim readback differs from masked write");

  // Reserved bits of any readback are zero
  property p_reserved_zero;
    @(posedge clk) disable iff (!rst_n)
    rd_valid |=> rd_ack && rd_data[15:9] == 7'h00 &&
      ($past(rd_req.kind) == czg_pkg::CZG_ZERO || !rd_data[8]);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved readback bits not zero");

endmodule : czg_trim_regs

`default_nettype wire
